// File: rtl/mmpc_top.sv
`timescale 1ns/1ps
`include "mmpc_params.svh"

module mmpc_top (
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  // register bus (avalon-mm slave)
  input  wire logic [9:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  output logic      [1:0]  avs_response_o,
  // system status
  input  wire logic        mode_select_pin_i,
  input  wire logic        stop_mode_i,
  input  wire logic        secured_i,
  // cpu local bus
  input  wire logic        cpu_req_i,
  input  wire logic [15:0] cpu_addr_i,
  input  wire logic        cpu_direct_i,
  input  wire logic        cpu_page_wr_i,
  input  wire logic [7:0]  cpu_page_data_i,
  output logic             cpu_stall_o,
  // background debug master local bus
  input  wire logic        dbg_req_i,
  input  wire logic [15:0] dbg_addr_i,
  output logic             dbg_stall_o,
  // global target bus
  output logic             tgt_valid_o,
  output logic [17:0]      tgt_addr_o,
  output logic             tgt_from_dbg_o,
  output logic             tgt_ifr_sel_o,
  output logic             illegal_reset_o,
  output logic             ext_bus_en_o,
  output logic             debug_control_o
);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [1:0] pin_sync_q;
  logic [1:0] stop_sync_q;
  logic [1:0] sec_sync_q;

  // no reset here: the pin must already be through both stages when reset lifts
  always_ff @(posedge clk_i) begin
    pin_sync_q <= {pin_sync_q[0], mode_select_pin_i};
  end

  // level inputs arrive from outside the clock domain
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      stop_sync_q <= 2'h0;
      sec_sync_q  <= 2'h0;
    end else begin
      stop_sync_q <= {stop_sync_q[0], stop_mode_i};
      sec_sync_q  <= {sec_sync_q[0], secured_i};
    end
  end

  logic pin_s;
  logic stop_s;
  logic sec_s;
  assign pin_s  = pin_sync_q[1];
  assign stop_s = stop_sync_q[1];
  assign sec_s  = sec_sync_q[1];

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic       acc_q;        // one wait state: answer on second edge
  logic       req;
  logic       wr_en;
  logic       hit;
  logic       lane0;

  assign req   = avs_read_i | avs_write_i;
  assign lane0 = avs_byteenable_i[0];
  assign hit   = (avs_address_i == `MMPC_ADDR_PAGE) | (avs_address_i == `MMPC_ADDR_DIRECT)
               | (avs_address_i == `MMPC_ADDR_MODE) | (avs_address_i == `MMPC_ADDR_CTL1)
               | (avs_address_i == `MMPC_ADDR_STATUS);
  assign wr_en = avs_write_i & acc_q & lane0;
  assign avs_waitrequest_o = req & ~acc_q;

  // access phase toggles so every request sees exactly one wait cycle
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      acc_q <= 1'b0;
    end else begin
      acc_q <= req & ~acc_q;
    end
  end

  // ----------------------------------------------------------------
  // mode register
  // ----------------------------------------------------------------
  logic armed_q;      // mode latched after reset release
  logic mode_q;       // 1 normal single chip, 0 special
  logic mode_lock_q;
  logic mode_now;
  logic special;
  logic mode_wr;

  // the pin rules while reset is held, the stored bit afterwards
  assign mode_now = armed_q ? mode_q : pin_s;
  assign special  = ~mode_now;
  assign mode_wr  = wr_en & (avs_address_i == `MMPC_ADDR_MODE);

  // reset value is a constant; the pin is captured at the first edge after release
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      armed_q     <= 1'b0;
      mode_q      <= 1'b0;
      mode_lock_q <= 1'b0;
    end else if (!armed_q) begin
      armed_q <= 1'b1;
      mode_q  <= pin_s;
    end else if (mode_wr && !sec_s && (special || !mode_lock_q)) begin
      // only special to normal is allowed; the reverse is refused and locks
      if (special) begin
        mode_q <= avs_writedata_i[`MMPC_MODE_BIT];
      end else if (!avs_writedata_i[`MMPC_MODE_BIT]) begin
        mode_lock_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // page, direct and control registers
  // ----------------------------------------------------------------
  logic [3:0] page_q;
  logic [7:0] direct_q;
  logic       direct_done_q;
  logic       ifr_on_q;
  localparam logic [7:0] PAGE_RESET = `MMPC_PAGE_RESET; // only the index bits are stored

  // the call/return path writes in its own cycle so the next fetch sees it
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      page_q <= PAGE_RESET[3:0];
    end else if (!stop_s && cpu_page_wr_i) begin
      page_q <= cpu_page_data_i[3:0];
    end else if (wr_en && avs_address_i == `MMPC_ADDR_PAGE) begin
      page_q <= avs_writedata_i[3:0];
    end
  end

  // write-once outside special mode
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      direct_q      <= `MMPC_DIRECT_RESET;
      direct_done_q <= 1'b0;
    end else if (wr_en && avs_address_i == `MMPC_ADDR_DIRECT && (special || !direct_done_q)) begin
      direct_q      <= avs_writedata_i[7:0];
      direct_done_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ifr_on_q <= 1'b0;
    end else if (wr_en && avs_address_i == `MMPC_ADDR_CTL1) begin
      ifr_on_q <= avs_writedata_i[`MMPC_IFR_BIT];
    end
  end

  // ----------------------------------------------------------------
  // read data and response
  // ----------------------------------------------------------------
  logic [7:0] rd_byte;

  always_comb begin
    case (avs_address_i)
      `MMPC_ADDR_PAGE:   rd_byte = {`MMPC_PAGE_UPPER, page_q};
      `MMPC_ADDR_DIRECT: rd_byte = direct_q;
      `MMPC_ADDR_MODE:   rd_byte = {mode_now, 7'h00};
      `MMPC_ADDR_CTL1:   rd_byte = {7'h00, ifr_on_q};
      `MMPC_ADDR_STATUS: rd_byte = {5'h00, mode_lock_q, direct_done_q, sec_s};
      default:           rd_byte = 8'h00;
    endcase
  end

  // data from flip-flops, loaded at the answering edge's preceding cycle
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      avs_readdata_o <= 32'h0;
      avs_response_o <= 2'h0;
    end else if (req && !acc_q) begin
      avs_readdata_o <= {24'h0, rd_byte};
      avs_response_o <= hit ? 2'h0 : 2'h3; // unmapped: decode error
    end
  end

  // ----------------------------------------------------------------
  // arbitration
  // ----------------------------------------------------------------
  logic [7:0] dbg_wait_q;
  logic       dbg_prio;
  logic       cpu_busy_q;   // cpu holds the bus for its current operation
  mmpc_pkg::mmpc_grant_t grant;

  // debug wins once it has waited more than the stall limit
  assign dbg_prio = (dbg_wait_q == `MMPC_DBG_STALL_MAX);

  always_comb begin
    grant = mmpc_pkg::MMPC_GRANT_NONE;
    if (!stop_s) begin
      if (dbg_req_i && (dbg_prio && !cpu_busy_q || !cpu_req_i)) begin
        grant = mmpc_pkg::MMPC_GRANT_DBG;
      end else if (cpu_req_i) begin
        grant = mmpc_pkg::MMPC_GRANT_CPU;
      end
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      dbg_wait_q <= 8'h00;
      cpu_busy_q <= 1'b0;
    end else begin
      cpu_busy_q <= (grant == mmpc_pkg::MMPC_GRANT_CPU) & ~dbg_prio;
      if (!dbg_req_i || grant == mmpc_pkg::MMPC_GRANT_DBG) begin
        dbg_wait_q <= 8'h00;
      end else if (!dbg_prio) begin
        dbg_wait_q <= dbg_wait_q + 8'h01;
      end
    end
  end

  assign cpu_stall_o = cpu_req_i & (grant != mmpc_pkg::MMPC_GRANT_CPU);
  assign dbg_stall_o = dbg_req_i & (grant != mmpc_pkg::MMPC_GRANT_DBG);

  // ----------------------------------------------------------------
  // local to global translation
  // ----------------------------------------------------------------
  logic [15:0] loc;
  logic [15:0] eff;
  logic [7:0]  gpage;
  logic [17:0] gaddr;
  logic        is_dbg;
  logic        mapped;

  assign is_dbg = (grant == mmpc_pkg::MMPC_GRANT_DBG);
  assign loc    = is_dbg ? dbg_addr_i : cpu_addr_i;
  // direct page replaces the high byte for direct-mode cpu accesses
  assign eff    = (!is_dbg && cpu_direct_i) ? {direct_q, loc[7:0]} : loc;

  always_comb begin
    case (eff[15:14])
      2'b00:   gpage = `MMPC_PAGE_FIX0;
      2'b01:   gpage = `MMPC_PAGE_FIX1;
      2'b10:   gpage = {`MMPC_PAGE_UPPER, page_q};
      default: gpage = `MMPC_PAGE_FIX3;
    endcase
  end

  // low global space keeps registers and info row unpaged
  assign gaddr = (eff[15:11] == 5'h00) ? {2'b00, eff} : {gpage[3:0], eff[13:0]};

  always_comb begin
    tgt_ifr_sel_o = ifr_on_q & (gaddr >= `MMPC_IFR_LO) & (gaddr <= `MMPC_IFR_HI);
    mapped = (gaddr <= `MMPC_REG_HI) | tgt_ifr_sel_o
           | ((gaddr >= `MMPC_RAM_LO) & (gaddr <= `MMPC_RAM_HI))
           | (gaddr >= `MMPC_FLASH_LO);
  end

  assign tgt_valid_o    = (grant != mmpc_pkg::MMPC_GRANT_NONE);
  assign tgt_addr_o     = gaddr;
  assign tgt_from_dbg_o = is_dbg;
  // only cpu accesses reset; debug reads of holes return undefined data
  assign illegal_reset_o = (grant == mmpc_pkg::MMPC_GRANT_CPU) & ~mapped;
  assign ext_bus_en_o    = 1'b0;
  assign debug_control_o = armed_q & special;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_page_window: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (tgt_valid_o && eff[15:14] == 2'b10) |-> (tgt_addr_o[17:14] == page_q))
    else $error("window page not used");
  a_fixed_top: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (tgt_valid_o && eff[15:14] == 2'b11) |-> (tgt_addr_o[17:14] == 4'hF))
    else $error("top block not fixed");
  a_direct_high: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (grant == mmpc_pkg::MMPC_GRANT_CPU && cpu_direct_i) |-> (eff[15:8] == direct_q))
    else $error("direct page not applied");
  a_direct_once: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    ($past(direct_done_q) && !special && $past(!special)) |-> $stable(direct_q))
    else $error("direct page rewritten");
  a_stop_idle: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    stop_s |-> !tgt_valid_o)
    else $error("access granted in stop");
  a_secure_mode: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    ($past(sec_s) && $past(armed_q)) |-> $stable(mode_q))
    else $error("mode changed while secured");
  a_call_page: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (cpu_page_wr_i && !stop_s) |=> (page_q == $past(cpu_page_data_i[3:0])))
    else $error("call page write late");
  a_dbg_starve: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (dbg_prio && dbg_req_i && !stop_s) |-> ##[0:2] !dbg_stall_o)
    else $error("debug master starved");
  a_no_ext: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    !ext_bus_en_o)
    else $error("external bus enabled");

  // reset, mode, map and arbitration checks
  a_page_reset: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    !armed_q |-> (page_q == PAGE_RESET[3:0]))
    else $error("page not at reset value");
  a_pin_latch: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    $rose(armed_q) |-> (mode_q == $past(pin_s)))
    else $error("mode pin not latched");
  a_mode_hold: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    ($past(armed_q) && !$past(mode_wr)) |-> $stable(mode_q))
    else $error("mode bit moved without a write");
  a_mode_refused: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (armed_q && mode_wr && !sec_s && !special && !avs_writedata_i[`MMPC_MODE_BIT])
    |=> (mode_lock_q && mode_q))
    else $error("refused mode write not locked");
  a_debug_ctl: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    armed_q |-> (debug_control_o == !mode_q))
    else $error("debug control does not follow mode");
  a_ifr_hidden: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    !ifr_on_q |-> !tgt_ifr_sel_o)
    else $error("info row visible while off");
  a_ifr_shown: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (ifr_on_q && tgt_addr_o[17:7] == 11'h008) |-> tgt_ifr_sel_o)
    else $error("info row hidden while on");
  a_hole_reset: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (grant == mmpc_pkg::MMPC_GRANT_CPU && tgt_addr_o[17:10] == 8'h01 && !ifr_on_q)
    |-> illegal_reset_o)
    else $error("cpu hole access not reset");
  a_dbg_no_reset: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    tgt_from_dbg_o |-> !illegal_reset_o)
    else $error("debug access caused reset");
  a_cpu_first: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (cpu_req_i && dbg_req_i && !dbg_prio && !stop_s)
    |-> (grant == mmpc_pkg::MMPC_GRANT_CPU))
    else $error("cpu lost arbitration early");
  a_window_low: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (tgt_valid_o && eff[15:14] == 2'b10) |-> (tgt_addr_o[13:0] == eff[13:0]))
    else $error("window offset not kept");
  a_low_flat: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (tgt_valid_o && eff[15:11] == 5'h00) |-> (tgt_addr_o == {2'b00, eff}))
    else $error("low space not flat");

  c_dbg_win: cover property (@(posedge clk_i) disable iff (!reset_n_i)
    dbg_prio && grant == mmpc_pkg::MMPC_GRANT_DBG && cpu_req_i);
  c_mode_lock: cover property (@(posedge clk_i) disable iff (!reset_n_i) $rose(mode_lock_q));
  c_ifr_hit: cover property (@(posedge clk_i) disable iff (!reset_n_i) tgt_ifr_sel_o);
  c_illegal: cover property (@(posedge clk_i) disable iff (!reset_n_i) illegal_reset_o);
  c_call_page: cover property (@(posedge clk_i) disable iff (!reset_n_i) cpu_page_wr_i && !stop_s);

endmodule

// File: rtl/mmpc_params.svh
`ifndef MMPC_PARAMS_SVH
`define MMPC_PARAMS_SVH
// register byte addresses (printed offsets are not multiples of four: index times four)
`define MMPC_IDX_PAGE       8'h30
`define MMPC_IDX_DIRECT     8'h31
`define MMPC_IDX_MODE       8'h32
`define MMPC_IDX_CTL1       8'h33
`define MMPC_IDX_STATUS     8'h34
`define MMPC_ADDR_PAGE      10'h0C0
`define MMPC_ADDR_DIRECT    10'h0C4
`define MMPC_ADDR_MODE      10'h0C8
`define MMPC_ADDR_CTL1      10'h0CC
`define MMPC_ADDR_STATUS    10'h0D0
// reset values and fixed pages
`define MMPC_PAGE_RESET     8'hFE
`define MMPC_PAGE_FIX0      8'hFC
`define MMPC_PAGE_FIX1      8'hFD
`define MMPC_PAGE_FIX3      8'hFF
`define MMPC_PAGE_UPPER     4'hF
`define MMPC_DIRECT_RESET   8'h00
// field positions
`define MMPC_MODE_BIT       7
`define MMPC_IFR_BIT        0
// info row window and memory map bounds in the global space
`define MMPC_IFR_LO         18'h00400
`define MMPC_IFR_HI         18'h0047F
`define MMPC_REG_HI         18'h003FF
`define MMPC_RAM_LO         18'h00800
`define MMPC_RAM_HI         18'h00FFF
`define MMPC_FLASH_LO       18'h38000
// arbitration: debug master gains priority after this many stalled cycles
`define MMPC_DBG_STALL_MAX  8'd128
`endif

// File: rtl/mmpc_pkg.sv
package mmpc_pkg;
  typedef enum logic [1:0] {
    MMPC_GRANT_NONE,
    MMPC_GRANT_CPU,
    MMPC_GRANT_DBG
  } mmpc_grant_t;
endpackage

// File: sim/mmpc_masters.sv
`timescale 1ns/1ps
// ----------------------------------------
// cpu and debug local bus masters
// ----------------------------------------
module mmpc_masters (
  input  wire logic        clk_i,
  input  wire logic        cpu_stall_i,
  input  wire logic        dbg_stall_i,
  input  wire logic        tgt_valid_i,
  input  wire logic [17:0] tgt_addr_i,
  input  wire logic        tgt_ifr_sel_i,
  input  wire logic        illegal_reset_i,
  output logic             cpu_req_o,
  output logic [15:0]      cpu_addr_o,
  output logic             cpu_direct_o,
  output logic             dbg_req_o,
  output logic [15:0]      dbg_addr_o
);
  // idle lines at time zero
  initial begin
    cpu_req_o = 1'b0;
    cpu_addr_o = 16'h0000;
    cpu_direct_o = 1'b0;
    dbg_req_o = 1'b0;
    dbg_addr_o = 16'h0000;
  end

  // one access, held until a grant is seen; gives up after 20 cycles
  task automatic access(input logic dbg, input logic [15:0] a, input logic d,
                        output logic ok, output logic [17:0] ga, output logic flash_info_row,
                        output logic ill);
    int n;
    n = 0;
    ok = 1'b0;
    @(posedge clk_i);
    if (dbg) begin
      dbg_req_o <= 1'b1;
      dbg_addr_o <= a;
    end else begin
      cpu_req_o <= 1'b1;
      cpu_addr_o <= a;
      cpu_direct_o <= d;
    end
    while (!ok && n < 20) begin
      @(posedge clk_i);
      ok = tgt_valid_i && !(dbg ? dbg_stall_i : cpu_stall_i);
      ga = tgt_addr_i;
      flash_info_row = tgt_ifr_sel_i;
      ill = illegal_reset_i;
      n++;
    end
    // released address shows the inverse so a stale value never passes as fresh
    cpu_req_o <= 1'b0;
    dbg_req_o <= 1'b0;
    cpu_addr_o <= ~cpu_addr_o;
    dbg_addr_o <= ~dbg_addr_o;
  endtask

  // both masters request at once; counts the cycles the debug side is held off
  task automatic contend(input logic [15:0] ca, input logic [15:0] da, output int waited,
                         output logic cpu_held);
    waited = 0;
    @(posedge clk_i);
    cpu_req_o <= 1'b1;
    cpu_addr_o <= ca;
    cpu_direct_o <= 1'b0;
    dbg_req_o <= 1'b1;
    dbg_addr_o <= da;
    @(posedge clk_i);
    while (dbg_stall_i !== 1'b0 && waited < 300) begin
      waited++;
      @(posedge clk_i);
    end
    cpu_held = cpu_stall_i;
    cpu_req_o <= 1'b0;
    dbg_req_o <= 1'b0;
    cpu_addr_o <= ~cpu_addr_o;
    dbg_addr_o <= ~dbg_addr_o;
  endtask
endmodule

// File: sim/tb_top.sv
`timescale 1ns/1ps
`include "mmpc_params.svh"
module tb_top;
  typedef struct packed { logic [15:0] a; logic d; logic [17:0] g; } mmpc_row_t;
  logic clk_i, reset_n_i, avs_read_i, avs_write_i, avs_waitrequest_o;
  logic [9:0]  avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o;
  logic [3:0]  avs_byteenable_i;
  logic [1:0]  avs_response_o;
  logic mode_select_pin_i, stop_mode_i, secured_i, cpu_req_i, cpu_direct_i, cpu_page_wr_i;
  logic [15:0] cpu_addr_i, dbg_addr_i;
  logic [7:0]  cpu_page_data_i;
  logic cpu_stall_o, dbg_req_i, dbg_stall_o, tgt_valid_o, tgt_from_dbg_o, tgt_ifr_sel_o;
  logic [17:0] tgt_addr_o, ga;
  logic illegal_reset_o, ext_bus_en_o, debug_control_o, ok, flash_info_row, ill;
  logic [31:0] q;
  logic [1:0]  r;
  int mismatches = 0;
  int checks = 0;
  int waited;
  // page 5, direct page 0x40
  mmpc_row_t rows [6] = '{'{16'h8123, 1'b0, 18'h14123}, '{16'hBFFF, 1'b0, 18'h17FFF},
    '{16'h4123, 1'b0, 18'h34123}, '{16'hC456, 1'b0, 18'h3C456},
    '{16'h1234, 1'b0, 18'h31234}, '{16'h00AB, 1'b1, 18'h340AB}};

  mmpc_top u_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .avs_response_o(avs_response_o),
    .mode_select_pin_i(mode_select_pin_i), .stop_mode_i(stop_mode_i), .secured_i(secured_i),
    .cpu_req_i(cpu_req_i), .cpu_addr_i(cpu_addr_i), .cpu_direct_i(cpu_direct_i),
    .cpu_page_wr_i(cpu_page_wr_i), .cpu_page_data_i(cpu_page_data_i),
    .cpu_stall_o(cpu_stall_o), .dbg_req_i(dbg_req_i), .dbg_addr_i(dbg_addr_i),
    .dbg_stall_o(dbg_stall_o), .tgt_valid_o(tgt_valid_o), .tgt_addr_o(tgt_addr_o),
    .tgt_from_dbg_o(tgt_from_dbg_o), .tgt_ifr_sel_o(tgt_ifr_sel_o),
    .illegal_reset_o(illegal_reset_o), .ext_bus_en_o(ext_bus_en_o),
    .debug_control_o(debug_control_o));

  mmpc_masters u_master (.clk_i(clk_i), .cpu_stall_i(cpu_stall_o), .dbg_stall_i(dbg_stall_o),
    .tgt_valid_i(tgt_valid_o), .tgt_addr_i(tgt_addr_o), .tgt_ifr_sel_i(tgt_ifr_sel_o),
    .illegal_reset_i(illegal_reset_o), .cpu_req_o(cpu_req_i), .cpu_addr_o(cpu_addr_i),
    .cpu_direct_o(cpu_direct_i), .dbg_req_o(dbg_req_i), .dbg_addr_o(dbg_addr_i));

  // ----------------------------------------
  // clock, checking and bus tasks
  // ----------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // request held until the edge that sees waitrequest low; data taken at that edge
  task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] d);
    @(posedge clk_i);
    avs_address_i <= a;
    avs_writedata_i <= {24'h000000, d};
    avs_write_i <= w;
    avs_read_i <= !w;
    @(posedge clk_i);
    while (avs_waitrequest_o !== 1'b0) begin
      @(posedge clk_i);
    end
    q = avs_readdata_o;
    r = avs_response_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask

  task automatic rdchk(input logic [9:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00);
    check(q, {24'h000000, exp});
  endtask

  // pin held steady well before release so the synchroniser sees it
  task automatic do_reset(input logic pin);
    reset_n_i <= 1'b0;
    mode_select_pin_i <= pin;
    repeat (6) @(posedge clk_i);
    reset_n_i <= 1'b1;
    repeat (2) @(posedge clk_i);
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // watchdog: the sequence needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    mismatches++;
    stop_test();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    reset_n_i = 1'b0;
    avs_address_i = 10'h000;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_writedata_i = 32'h00000000;
    avs_byteenable_i = 4'hF;
    mode_select_pin_i = 1'b1;
    stop_mode_i = 1'b0;
    secured_i = 1'b0;
    cpu_page_wr_i = 1'b0;
    cpu_page_data_i = 8'h00;
    do_reset(1'b1);
    rdchk(`MMPC_ADDR_PAGE, 8'hFE);
    rdchk(`MMPC_ADDR_MODE, 8'h80);
    check(ext_bus_en_o, 1'b0);
    check(debug_control_o, 1'b0);
    bus(1'b1, `MMPC_ADDR_DIRECT, 8'h40);
    bus(1'b1, `MMPC_ADDR_DIRECT, 8'h22);
    rdchk(`MMPC_ADDR_DIRECT, 8'h40);
    bus(1'b1, `MMPC_ADDR_PAGE, 8'h05);
    rdchk(`MMPC_ADDR_PAGE, 8'hF5);
    foreach (rows[i]) begin
      u_master.access(1'b0, rows[i].a, rows[i].d, ok, ga, flash_info_row, ill);
      check({14'h0000, ga}, {14'h0000, rows[i].g});
    end
    u_master.access(1'b1, 16'h8010, 1'b0, ok, ga, flash_info_row, ill);
    check({14'h0000, ga}, 32'h00014010);
    // debug stalled past 128 cycles takes the bus once the cpu operation ends
    u_master.contend(16'hC000, 16'hC010, waited, ill);
    check(waited, 129);
    check(ill, 1'b1);
    // call/return page path: one-cycle pulse takes effect at once
    @(posedge clk_i);
    cpu_page_wr_i <= 1'b1;
    cpu_page_data_i <= 8'h07;
    @(posedge clk_i);
    cpu_page_wr_i <= 1'b0;
    rdchk(`MMPC_ADDR_PAGE, 8'hF7);
    bus(1'b1, `MMPC_ADDR_MODE, 8'h00);
    rdchk(`MMPC_ADDR_MODE, 8'h80);
    rdchk(`MMPC_ADDR_STATUS, 8'h06);
    bus(1'b1, `MMPC_ADDR_CTL1, 8'h01);
    u_master.access(1'b0, 16'h0420, 1'b0, ok, ga, flash_info_row, ill);
    check(flash_info_row, 1'b1);
    bus(1'b1, `MMPC_ADDR_CTL1, 8'h00);
    u_master.access(1'b0, 16'h0420, 1'b0, ok, ga, flash_info_row, ill);
    check({flash_info_row, ill}, 2'b01);
    bus(1'b0, 10'h100, 8'h00);
    check(r, 2'b11);
    // stop mode: synced input, so let it settle first
    stop_mode_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    u_master.access(1'b0, 16'hC000, 1'b0, ok, ga, flash_info_row, ill);
    check(ok, 1'b0);
    stop_mode_i <= 1'b0;
    do_reset(1'b0);
    rdchk(`MMPC_ADDR_MODE, 8'h00);
    check(debug_control_o, 1'b1);
    bus(1'b1, `MMPC_ADDR_DIRECT, 8'h11);
    bus(1'b1, `MMPC_ADDR_DIRECT, 8'h22);
    rdchk(`MMPC_ADDR_DIRECT, 8'h22);
    secured_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    bus(1'b1, `MMPC_ADDR_MODE, 8'h80);
    rdchk(`MMPC_ADDR_MODE, 8'h00);
    secured_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    bus(1'b1, `MMPC_ADDR_MODE, 8'h80);
    rdchk(`MMPC_ADDR_MODE, 8'h80);
    stop_test();
  end
endmodule
